//--- logic/mcit_pkg.sv
// Purpose: Shared constants and types for the instruction timing core
// Assumes: One system clock, 8-bit data path, 16-bit program addresses
// Notes: Opcode values follow the standard encoding of this instruction set

package mcit_pkg;

  // ----------------------------------------------------------------
  // Special function register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_PTR_LOW = 8'h82;
  localparam logic [7:0] SFR_PTR_HIGH = 8'h83;
  localparam logic [7:0] SFR_ACCUM = 8'hE0;
  localparam logic [7:0] PTR_LOW_RESET = 8'h00;
  localparam logic [7:0] PTR_HIGH_RESET = 8'h00;
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic [7:0] DIRECT_SFR_BASE = 8'h80;
  localparam int PAGE_BITS = 11;

  // ----------------------------------------------------------------
  // Opcodes the core acts on beyond timing, and some it only times
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_SPARE = 8'hA5;
  localparam logic [7:0] OP_CLR_A = 8'hE4;
  localparam logic [7:0] OP_CPL_A = 8'hF4;
  localparam logic [7:0] OP_RL_A = 8'h23;
  localparam logic [7:0] OP_RLC_A = 8'h33;
  localparam logic [7:0] OP_RR_A = 8'h03;
  localparam logic [7:0] OP_RRC_A = 8'h13;
  localparam logic [7:0] OP_SWAP_A = 8'hC4;
  localparam logic [7:0] OP_CLR_C = 8'hC3;
  localparam logic [7:0] OP_SETB_C = 8'hD3;
  localparam logic [7:0] OP_CPL_C = 8'hB3;
  localparam logic [7:0] OP_LOAD_PTR = 8'h90;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_BIT_CLEAR_JUMP = 8'h10;
  localparam logic [7:0] OP_COMPARE_JUMP_DIR = 8'hB5;
  localparam logic [7:0] OP_EXT_READ_PTR = 8'hE0;
  localparam logic [7:0] OP_PUSH = 8'hC0;
  localparam logic [7:0] OP_NIBBLE_XCH = 8'hD6;

  // ----------------------------------------------------------------
  // Branch classes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BR_NONE = 4'h0,
    BR_ALWAYS_REL = 4'h1,
    BR_C = 4'h2,
    BR_NC = 4'h3,
    BR_Z = 4'h4,
    BR_NZ = 4'h5,
    BR_EXT = 4'h6,
    BR_PAGED = 4'h7,
    BR_FULL = 4'h8,
    BR_INDIRECT = 4'h9,
    BR_RETURN = 4'hA
  } mcit_branch_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } mcit_state_t;

endpackage

//--- logic/mcit_decode.sv
// Purpose: Byte count, base clock count and branch class per opcode
// Assumes: Pure combinational lookup
// Notes: Conditional branches report the not-taken count

`timescale 1ns/1ps

module mcit_decode import mcit_pkg::*; (
  input wire logic [7:0] opcode,
  output logic [1:0] num_bytes,
  output logic [2:0] base_cycles,
  output mcit_branch_t kind
);

  always_comb begin
    num_bytes = 2'd1;
    base_cycles = 3'd1;
    kind = BR_NONE;
    casez (opcode)
      8'b???00001: begin num_bytes = 2'd2; base_cycles = 3'd3; kind = BR_PAGED; end
      8'b???10001: begin num_bytes = 2'd2; base_cycles = 3'd3; kind = BR_PAGED; end
      8'h02, 8'h12: begin num_bytes = 2'd3; base_cycles = 3'd4; kind = BR_FULL; end
      8'h22, 8'h32: begin base_cycles = 3'd5; kind = BR_RETURN; end
      8'h80: begin num_bytes = 2'd2; base_cycles = 3'd3; kind = BR_ALWAYS_REL; end
      8'h73: begin base_cycles = 3'd3; kind = BR_INDIRECT; end
      8'h40: begin num_bytes = 2'd2; base_cycles = 3'd2; kind = BR_C; end
      8'h50: begin num_bytes = 2'd2; base_cycles = 3'd2; kind = BR_NC; end
      8'h60: begin num_bytes = 2'd2; base_cycles = 3'd2; kind = BR_Z; end
      8'h70: begin num_bytes = 2'd2; base_cycles = 3'd2; kind = BR_NZ; end
      8'h10, 8'h20, 8'h30: begin num_bytes = 2'd3; base_cycles = 3'd3; kind = BR_EXT; end
      8'hB5, 8'b1011_011?: begin num_bytes = 2'd3; base_cycles = 3'd4; kind = BR_EXT; end
      8'hB4, 8'b1011_1???: begin num_bytes = 2'd3; base_cycles = 3'd3; kind = BR_EXT; end
      8'hD5: begin num_bytes = 2'd3; base_cycles = 3'd3; kind = BR_EXT; end
      8'b1101_1???: begin num_bytes = 2'd2; base_cycles = 3'd2; kind = BR_EXT; end
      8'h90, 8'h85, 8'h75: begin num_bytes = 2'd3; base_cycles = 3'd3; end
      8'h83, 8'h93: base_cycles = 3'd3;
      8'hE0, 8'hF0, 8'b111?001?: base_cycles = 3'd3;
      8'hE5, 8'h74, 8'hF5, 8'hC5, 8'hC0, 8'hD0, 8'b1010_1???, 8'b0111_1???, 8'b1000_1???,
      8'b1000_011?, 8'b1010_011?, 8'b0111_011?: begin num_bytes = 2'd2; base_cycles = 3'd2; end
      8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92: begin
        num_bytes = 2'd2; base_cycles = 3'd2;
      end
      8'b1110_011?, 8'b1111_011?, 8'b1100_011?, 8'b1101_011?: base_cycles = 3'd2;
      default: base_cycles = 3'd1;
    endcase
  end

endmodule // mcit_decode

//--- logic/mcit_target.sv
// Purpose: Branch destination arithmetic
// Assumes: pc_next is the address of the byte after the whole instruction
// Notes: Return targets come from the stack outside; pc_next is passed through

`timescale 1ns/1ps

module mcit_target import mcit_pkg::*; (
  input mcit_branch_t kind,
  input wire logic [1:0] num_bytes,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic [15:0] pc_next,
  input wire logic [7:0] acc,
  input wire logic [15:0] data_pointer,
  output logic [15:0] target
);

  logic [7:0] rel;

  always_comb begin
    rel = (num_bytes == 2'd3) ? operand2 : operand1;
    case (kind)
      BR_PAGED: target = {pc_next[15:PAGE_BITS], opcode[7:5], operand1};
      BR_FULL: target = {operand1, operand2};
      BR_INDIRECT: target = data_pointer + {8'h00, acc};
      BR_NONE, BR_RETURN: target = pc_next;
      default: target = pc_next + {{8{rel[7]}}, rel};
    endcase
  end

endmodule // mcit_target

//--- logic/mcit_core.sv
// Purpose: Instruction timing, branch resolution and data pointer of the core
// Assumes: Instruction bytes and pc_next arrive together with instr_valid
// Notes: Tests of direct bits and compares are resolved outside via ext_cond
//
// How it works
// - Accumulator clear/complement/rotate/swap take one clock.
// - Register moves one clock, indirect moves two.
// - Direct/immediate to direct moves: three bytes, clocks.
// - Immediate pointer load: three bytes, three clocks.
// - Code byte reads take three clocks.
// - External data moves take three clocks.
// - Push and pop take two clocks.
// - Nibble exchange swaps low nibbles, two clocks.
// - Carry ops one clock, bit ops two.
// - Carry/zero jumps take two or three clocks.
// - Bit test jumps take three or four.
// - Compare jumps take four/five or three/four.
// - Decrement jumps take two/three or three/four.
// - Short and indirect jumps take three clocks.
// - Relative target is next address plus offset.
// - Direct address upper half selects function registers.
// - Paged target stays in the 2 kB page.
// - Long call/jump carry full 16-bit target.
// - Unused opcode behaves like no-operation except bank_index and indirect_index.
// - Bank register eight choices; indirect uses first two.
// - Pointer is two zero-reset byte registers.
// - Not taken uses lower count, taken higher.

`timescale 1ns/1ps

module mcit_core import mcit_pkg::*; #(
  parameter int CYCLE_WIDTH = 3
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic [15:0] pc_next,
  input wire logic ext_cond,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic busy,
  output logic done,
  output logic branch_taken,
  output logic [15:0] target,
  output logic [1:0] instr_bytes,
  output logic [7:0] acc,
  output logic carry,
  output logic [15:0] data_pointer,
  output logic [7:0] sfr_rdata,
  output logic dir_is_sfr,
  output logic [2:0] bank_index,
  output logic indirect_index,
  output logic bit_clear,
  output logic [7:0] mem_wdata,
  output logic mem_wr
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (CYCLE_WIDTH < 3) begin : g_bad_width
    $error("CYCLE_WIDTH must hold a count of five");
  end

  // ----------------------------------------------------------------
  // Decode and target
  // ----------------------------------------------------------------
  logic [1:0] dec_bytes;
  logic [2:0] dec_cycles;
  mcit_branch_t dec_kind;
  logic [15:0] calc_target;
  logic cond_true;
  logic is_cond;
  logic take;
  logic [CYCLE_WIDTH-1:0] run_cycles;

  mcit_decode u_decode (
    .opcode(opcode),
    .num_bytes(dec_bytes),
    .base_cycles(dec_cycles),
    .kind(dec_kind)
  );

  mcit_target u_target (
    .kind(dec_kind),
    .num_bytes(dec_bytes),
    .opcode(opcode),
    .operand1(operand1),
    .operand2(operand2),
    .pc_next(pc_next),
    .acc(acc),
    .data_pointer(data_pointer),
    .target(calc_target)
  );

  always_comb begin
    is_cond = 1'b0;
    case (dec_kind)
      BR_ALWAYS_REL, BR_PAGED, BR_FULL, BR_INDIRECT, BR_RETURN: cond_true = 1'b1;
      BR_C: begin cond_true = carry; is_cond = 1'b1; end
      BR_NC: begin cond_true = !carry; is_cond = 1'b1; end
      BR_Z: begin cond_true = (acc == 8'h00); is_cond = 1'b1; end
      BR_NZ: begin cond_true = (acc != 8'h00); is_cond = 1'b1; end
      BR_EXT: begin cond_true = ext_cond; is_cond = 1'b1; end
      default: cond_true = 1'b0;
    endcase
    // Taken conditional branches cost exactly one extra clock
    run_cycles = CYCLE_WIDTH'(dec_cycles) + CYCLE_WIDTH'(is_cond && cond_true);
  end

  // ----------------------------------------------------------------
  // Control: sequencing of one instruction
  // ----------------------------------------------------------------
  mcit_state_t state;
  mcit_state_t next_state;
  logic [CYCLE_WIDTH-1:0] cnt;
  logic [CYCLE_WIDTH-1:0] next_cnt;
  logic next_busy;
  logic next_done;
  logic next_branch_taken;
  logic [15:0] next_target;
  logic [1:0] next_instr_bytes;
  logic next_dir_is_sfr;
  logic [2:0] next_bank_index;
  logic next_indirect_index;

  assign take = (state == ST_IDLE) && instr_valid;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    next_branch_taken = branch_taken;
    next_target = target;
    next_instr_bytes = instr_bytes;
    next_dir_is_sfr = dir_is_sfr;
    next_bank_index = bank_index;
    next_indirect_index = indirect_index;
    unique case (state)
      ST_IDLE: begin
        if (instr_valid) begin
          next_state = ST_EXEC;
          next_busy = 1'b1;
          next_cnt = run_cycles - CYCLE_WIDTH'(1);
          next_branch_taken = (dec_kind != BR_NONE) && cond_true;
          next_target = calc_target;
          next_instr_bytes = dec_bytes;
          next_dir_is_sfr = (operand1 >= DIRECT_SFR_BASE);
          next_bank_index = opcode[2:0];
          next_indirect_index = opcode[0];
        end
      end
      ST_EXEC: begin
        if (cnt == '0) begin
          next_state = ST_IDLE;
          next_busy = 1'b0;
          next_done = 1'b1;
        end else begin
          next_cnt = cnt - CYCLE_WIDTH'(1);
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      branch_taken <= 1'b0;
      target <= 16'h0000;
      instr_bytes <= 2'd0;
      dir_is_sfr <= 1'b0;
      bank_index <= 3'd0;
      indirect_index <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
      branch_taken <= next_branch_taken;
      target <= next_target;
      instr_bytes <= next_instr_bytes;
      dir_is_sfr <= next_dir_is_sfr;
      bank_index <= next_bank_index;
      indirect_index <= next_indirect_index;
    end
  end

  // ----------------------------------------------------------------
  // Data: accumulator, carry, pointer and register port
  // ----------------------------------------------------------------
  logic [7:0] next_acc;
  logic next_carry;
  logic [15:0] next_data_pointer;
  logic [7:0] next_sfr_rdata;
  logic next_bit_clear;
  logic [7:0] next_mem_wdata;
  logic next_mem_wr;

  always_comb begin
    next_acc = acc;
    next_carry = carry;
    next_data_pointer = data_pointer;
    next_sfr_rdata = sfr_rdata;
    next_bit_clear = 1'b0;
    next_mem_wdata = mem_wdata;
    next_mem_wr = 1'b0;
    if (sfr_rd) begin
      case (sfr_addr)
        SFR_PTR_LOW: next_sfr_rdata = data_pointer[7:0];
        SFR_PTR_HIGH: next_sfr_rdata = data_pointer[15:8];
        SFR_ACCUM: next_sfr_rdata = acc;
        default: next_sfr_rdata = 8'h00;
      endcase
    end
    if (sfr_wr) begin
      case (sfr_addr)
        SFR_PTR_LOW: next_data_pointer[7:0] = sfr_wdata;
        SFR_PTR_HIGH: next_data_pointer[15:8] = sfr_wdata;
        SFR_ACCUM: next_acc = sfr_wdata;
        default: next_acc = acc;
      endcase
    end
    // An instruction that lands in the same cycle as a port write wins
    if (take) begin
      case (opcode)
        OP_CLR_A: next_acc = 8'h00;
        OP_CPL_A: next_acc = ~acc;
        OP_RL_A: next_acc = {acc[6:0], acc[7]};
        OP_RR_A: next_acc = {acc[0], acc[7:1]};
        OP_RLC_A: begin next_acc = {acc[6:0], carry}; next_carry = acc[7]; end
        OP_RRC_A: begin next_acc = {carry, acc[7:1]}; next_carry = acc[0]; end
        OP_SWAP_A: next_acc = {acc[3:0], acc[7:4]};
        OP_CLR_C: next_carry = 1'b0;
        OP_SETB_C: next_carry = 1'b1;
        OP_CPL_C: next_carry = !carry;
        OP_LOAD_PTR: next_data_pointer = {operand1, operand2};
        OP_BIT_CLEAR_JUMP: next_bit_clear = ext_cond;
        default: next_mem_wr = 1'b0;
      endcase
      if (opcode[7:1] == OP_NIBBLE_XCH[7:1]) begin
        next_acc = {acc[7:4], mem_rdata[3:0]};
        next_mem_wdata = {mem_rdata[7:4], acc[3:0]};
        next_mem_wr = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acc <= ACCUM_RESET;
      carry <= 1'b0;
      data_pointer <= {PTR_HIGH_RESET, PTR_LOW_RESET};
      sfr_rdata <= 8'h00;
      bit_clear <= 1'b0;
      mem_wdata <= 8'h00;
      mem_wr <= 1'b0;
    end else begin
      acc <= next_acc;
      carry <= next_carry;
      data_pointer <= next_data_pointer;
      sfr_rdata <= next_sfr_rdata;
      bit_clear <= next_bit_clear;
      mem_wdata <= next_mem_wdata;
      mem_wr <= next_mem_wr;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [15:0] rel_ext;
  logic op_is_sfr;
  assign rel_ext = {{8{operand1[7]}}, operand1};
  assign op_is_sfr = operand1[7];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_spare_as_nop: assert property (take && opcode == OP_SPARE |=> busy ##1 (done && !busy))
    else $error("spare opcode not one clock");
  a_accum_clear: assert property (take && opcode == OP_CLR_A |=> acc == 8'h00 ##1 done)
    else $error("clear accumulator wrong");
  a_ext_move_time: assert property (take && opcode == OP_EXT_READ_PTR |=> busy[*3] ##1 done)
    else $error("external move not three clocks");
  a_push_time: assert property (take && opcode == OP_PUSH |=> busy[*2] ##1 done)
    else $error("push not two clocks");
  a_compare_taken: assert property (take && opcode == OP_COMPARE_JUMP_DIR && ext_cond
    |=> busy[*5] ##1 done)
    else $error("taken compare not five clocks");
  a_jz_not_taken: assert property (take && opcode == OP_JZ && acc != 8'h00
    |=> !branch_taken && busy[*2] ##1 done)
    else $error("untaken zero jump wrong");
  a_rel_target: assert property (take && opcode == OP_SHORT_JUMP
    |=> target == $past(pc_next) + $past(rel_ext))
    else $error("relative target wrong");
  a_ptr_load: assert property (take && opcode == OP_LOAD_PTR
    |=> data_pointer == {$past(operand1), $past(operand2)})
    else $error("pointer load wrong");
  a_direct_space: assert property (take |=> dir_is_sfr == $past(op_is_sfr))
    else $error("direct space select wrong");
  a_ptr_port_write: assert property (sfr_wr && sfr_addr == SFR_PTR_LOW && !take
    |=> data_pointer[7:0] == $past(sfr_wdata))
    else $error("pointer low write lost");

  c_ext_branch_taken: cover property (take && dec_kind == BR_EXT && ext_cond);
  c_nibble_xch: cover property (take && opcode == OP_NIBBLE_XCH);
  c_paged_jump: cover property (take && dec_kind == BR_PAGED ##1 busy[*3] ##1 done);
  c_ptr_readback: cover property (sfr_rd && sfr_addr == SFR_PTR_HIGH);

endmodule // mcit_core

//--- tb/mcu_core_instruction_timing_tb.sv
// Purpose: Self-checking bench for the instruction timing core
// Assumes: Core answers with busy for N cycles and a done pulse
// Notes: Expectations queue at the take edge, a monitor pops them on done

`timescale 1ns/1ps

module mcu_core_instruction_timing_tb;
  import mcit_pkg::*;

  typedef struct {
    int n;
    logic [1:0] nb;
    logic tk, ct, cy, ds, ii, mwr, bc;
    logic [15:0] tg, dp;
    logic [7:0] ac, mwd;
    logic [2:0] bi;
  } mcit_exp_t;

  logic mclk, resetn, instr_valid, ext_cond, sfr_wr, sfr_rd;
  logic [7:0] opcode, operand1, operand2, mem_rdata, sfr_addr, sfr_wdata;
  logic [15:0] pc_next;
  logic busy, done, branch_taken, carry, dir_is_sfr, indirect_index, bit_clear, mem_wr;
  logic [15:0] target, data_pointer;
  logic [1:0] instr_bytes;
  logic [7:0] acc, sfr_rdata, mem_wdata;
  logic [2:0] bank_index;
  int err_count, n_compared, cnt, cyc;
  logic s_mwr, s_bc;
  logic [7:0] s_mwd, m_acc;
  logic [15:0] m_dp;
  logic m_c;
  mcit_exp_t exp_q[$];
  mcit_exp_t e;
  // ----------------------------------------------------------------
  // Opcode table: {opcode, bytes, clocks, branch class}
  // ----------------------------------------------------------------
  logic [19:0] tbl[$] = '{
    20'hE4110, 20'hF4110, 20'h23110, 20'h33110, 20'h03110, 20'h13110, 20'hC4110,
    20'hE8110, 20'hE6120, 20'hF6120,
    20'h85330, 20'h75330, 20'h90330,
    20'h93130, 20'h83130, 20'hE2130, 20'hF2130, 20'hE0130, 20'hF0130,
    20'hC0220, 20'hD0220, 20'hD6120,
    20'hC3110, 20'hD3110, 20'hB3110, 20'hC2220, 20'hD2220, 20'hB2220,
    20'h82220, 20'hB0220, 20'h72220, 20'hA0220, 20'hA2220, 20'h92220,
    20'h00110, 20'hA5110, 20'h11237, 20'h12348, 20'h2215A, 20'h3215A,
    20'h01237, 20'h02348, 20'h80231, 20'h73139,
    20'h40222, 20'h50223, 20'h60224, 20'h70225, 20'h20336, 20'h30336,
    20'h10336, 20'hB5346, 20'hB4336, 20'hB8336, 20'hB6346, 20'hD8226, 20'hD5336
  };

  mcit_core #(.CYCLE_WIDTH(3)) i_dut (
    .mclk(mclk), .resetn(resetn), .instr_valid(instr_valid), .opcode(opcode),
    .operand1(operand1), .operand2(operand2), .pc_next(pc_next), .ext_cond(ext_cond),
    .mem_rdata(mem_rdata), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .busy(busy), .done(done), .branch_taken(branch_taken),
    .target(target), .instr_bytes(instr_bytes), .acc(acc), .carry(carry),
    .data_pointer(data_pointer), .sfr_rdata(sfr_rdata), .dir_is_sfr(dir_is_sfr),
    .bank_index(bank_index), .indirect_index(indirect_index), .bit_clear(bit_clear),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Drivers, entered and left at a rising edge
  // ----------------------------------------------------------------
  // Held until taken, so the busy window sees (and must refuse) the request
  task automatic issue(input logic [19:0] ent);
    logic [7:0] op, o1, o2, mr, rel;
    logic [31:0] r;
    logic [15:0] pc;
    logic ex, cond;
    int cl, ok;
    mcit_exp_t x;
    r = $urandom;
    pc = 16'($urandom);
    op = ent[19:12];
    cl = int'(ent[3:0]);
    o1 = r[7:0];
    o2 = r[15:8];
    mr = r[23:16];
    ex = r[24];
    if (cl == 7) op[7:5] = r[27:25];
    if (op[3:0] == 4'h8) op[2:0] = r[30:28];
    if (op inside {8'hE6, 8'hF6, 8'hB6, 8'hD6, 8'hE2, 8'hF2}) op[0] = r[31];
    instr_valid <= 1'b1;
    opcode <= op;
    operand1 <= o1;
    operand2 <= o2;
    pc_next <= pc;
    mem_rdata <= mr;
    ext_cond <= ex;
    ok = 0;
    // Idle is judged at the falling edge, so the take edge never races the core
    for (int k = 0; k < 10; k++) begin
      @(negedge mclk);
      ok = (busy === 1'b0) ? 1 : 0;
      @(posedge mclk);
      if (ok == 1) break;
    end
    chk(ok == 1, "instruction never taken");
    rel = (ent[9:8] == 2'd2) ? o1 : o2;
    cond = (cl == 2) ? m_c : (cl == 3) ? !m_c : (cl == 4) ? (m_acc == 8'h00) :
           (cl == 5) ? (m_acc != 8'h00) : ex;
    x.tk = (cl == 0) ? 1'b0 : (cl inside {[2:6]}) ? cond : 1'b1;
    x.n = int'(ent[7:4]) + ((cl inside {[2:6]} && x.tk) ? 1 : 0);
    x.ct = !(cl inside {[2:6]}) || x.tk;
    case (cl)
      0, 10: x.tg = pc;
      7: x.tg = {pc[15:11], op[7:5], o1};
      8: x.tg = {o1, o2};
      9: x.tg = {8'h00, m_acc} + m_dp;
      default: x.tg = pc + {{8{rel[7]}}, rel};
    endcase
    x.mwr = 1'b0;
    x.mwd = {mr[7:4], m_acc[3:0]};
    x.bc = (op == 8'h10) && ex;
    case (op)
      8'hE4: m_acc = 8'h00;
      8'hF4: m_acc = ~m_acc;
      8'h23: m_acc = {m_acc[6:0], m_acc[7]};
      8'h33: {m_c, m_acc} = {m_acc, m_c};
      8'h03: m_acc = {m_acc[0], m_acc[7:1]};
      8'h13: {m_acc, m_c} = {m_c, m_acc};
      8'hC4: m_acc = {m_acc[3:0], m_acc[7:4]};
      8'hC3: m_c = 1'b0;
      8'hD3: m_c = 1'b1;
      8'hB3: m_c = ~m_c;
      8'h90: m_dp = {o1, o2};
      8'hD6, 8'hD7: begin
        x.mwr = 1'b1;
        m_acc = {m_acc[7:4], mr[3:0]};
      end
      default: ;
    endcase
    x.nb = ent[9:8];
    x.ac = m_acc;
    x.cy = m_c;
    x.dp = m_dp;
    x.ds = o1 >= DIRECT_SFR_BASE;
    x.bi = op[2:0];
    x.ii = op[0];
    exp_q.push_back(x);
  endtask

  task automatic idle();
    instr_valid <= 1'b0;
    for (int k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (exp_q.size() == 0) break;
    end
  endtask

  task automatic special_function_register(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] x);
    sfr_wr <= w;
    sfr_rd <= !w;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge mclk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    if (w && a == SFR_PTR_LOW) m_dp[7:0] = d;
    if (w && a == SFR_PTR_HIGH) m_dp[15:8] = d;
    if (w && a == SFR_ACCUM) m_acc = d;
    @(negedge mclk);
    if (!w) chk(sfr_rdata === x, "register read");
    chk(data_pointer === m_dp && acc === m_acc, "register write");
    @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Monitor: pulses are caught in the first busy cycle, all else on done
  // ----------------------------------------------------------------
  always @(negedge mclk) begin
    if (resetn !== 1'b1) begin
      cnt = 0;
    end else begin
      if (busy === 1'b1) begin
        if (cnt == 0) begin
          s_mwr = mem_wr;
          s_mwd = mem_wdata;
          s_bc = bit_clear;
        end
        cnt++;
      end
      if (done === 1'b1) begin
        if (exp_q.size() == 0) begin
          chk(1'b0, "done without instruction");
        end else begin
          e = exp_q.pop_front();
          chk(cnt == e.n, "clock count");
          chk(instr_bytes === e.nb, "byte count");
          chk(branch_taken === e.tk, "branch decision");
          if (e.ct) chk(target === e.tg, "branch target");
          chk(acc === e.ac && carry === e.cy, "accumulator or carry");
          chk(data_pointer === e.dp, "pointer load");
          chk(dir_is_sfr === e.ds, "direct space");
          chk(bank_index === e.bi && indirect_index === e.ii, "register select");
          chk(s_mwr === e.mwr && (!e.mwr || s_mwd === e.mwd), "nibble write");
          chk(s_bc === e.bc, "bit clear");
        end
        cnt = 0;
      end
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    {instr_valid, ext_cond, sfr_wr, sfr_rd, resetn} = '0;
    {opcode, operand1, operand2, mem_rdata, sfr_addr, sfr_wdata} = '0;
    pc_next = 16'h0000;
    {err_count, n_compared, cnt, cyc} = '0;
    {m_acc, m_dp, m_c} = '0;
    void'($urandom(48));
    repeat (20) @(posedge mclk);
    chk(busy === 1'b0 && data_pointer === 16'h0000 && acc === 8'h00, "reset state");
    resetn <= 1'b1;
    @(posedge mclk);
    special_function_register(1'b0, SFR_PTR_LOW, 8'h00, PTR_LOW_RESET);
    special_function_register(1'b0, SFR_PTR_HIGH, 8'h00, PTR_HIGH_RESET);
    special_function_register(1'b1, SFR_PTR_LOW, 8'h5A, 8'h00);
    special_function_register(1'b1, SFR_PTR_HIGH, 8'hA5, 8'h00);
    special_function_register(1'b0, SFR_PTR_LOW, 8'h00, 8'h5A);
    special_function_register(1'b0, SFR_PTR_HIGH, 8'h00, 8'hA5);
    special_function_register(1'b1, 8'h81, 8'hFF, 8'h00);
    special_function_register(1'b0, 8'h81, 8'h00, 8'h00);
    foreach (tbl[i]) issue(tbl[i]);
    idle();
    for (int i = 0; i < 300; i++) begin
      issue(tbl[$urandom_range(tbl.size() - 1)]);
      if ($urandom_range(7) == 0) begin
        idle();
        special_function_register(1'b1, 8'(($urandom_range(2) == 0) ? 8'hE0 : 8'h82 + $urandom_range(1)),
            8'($urandom), 8'h00);
        special_function_register(1'b0, SFR_ACCUM, 8'h00, m_acc);
      end
    end
    idle();
    resetn <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk(data_pointer === 16'h0000 && acc === 8'h00 && busy === 1'b0, "second reset");
    {m_acc, m_dp, m_c} = '0;
    @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    issue(20'h60224);
    issue(20'hA5110);
    idle();
    // A result that never came must not reach the verdict as a pass
    chk(exp_q.size() == 0, "results missing");
    close_out();
  end
endmodule // mcu_core_instruction_timing_tb
